/* File: swp_decode.sv */
// Sweep trigger and mode decoder with its AHB-Lite register slave
//
// Overview of operation
// - Burst source matters only in burst mode, and only with external increments.
// - Burst source one with external increments: control pin steps and gates burst.
// - Burst source zero: burst timed internally from the burst length register.
// - Burst length counts either clock periods or output waveform cycles.
// - With internal increments the burst source bit is ignored.
// - Increment source one: step only on a rising edge of the control pin.
// - Increment source zero: step automatically from the internal interval timer.
// - Shape one gives sawtooth restarting at start; zero gives up-down triangle.
// - Sync select acts only with sync enable; picks end of sweep or each step.
// - Sync select one: sync high at end of sweep, low when next sweep starts.
// - In burst mode output frequency for burst length, midscale for the rest.
`timescale 1ns/10ps
module swp_decode (
  // Clock, reset, enable
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // External trigger and waveform feedback
  input wire logic ext_ctrl,
  input wire logic wave_cycle_tick,
  // Sweep outputs
  output logic [swp_pkg::SWP_STEP_W-1:0] step_index,
  output logic direction_down,
  output logic step_pulse,
  output logic burst_active,
  output logic sweep_finished,
  output logic sync_output_pin
);
  import swp_pkg::*;

  // ****************************************
  // Register bus
  // ****************************************
  logic [7:0] cfg;
  logic [15:0] intv;
  logic [15:0] blen;
  logic [11:0] nstep;
  logic wr_pend;
  logic [7:0] wr_addr;
  logic [7:0] next_cfg;
  logic [15:0] next_intv;
  logic [15:0] next_blen;
  logic [11:0] next_nstep;
  logic next_wr_pend;
  logic [7:0] next_wr_addr;
  logic [31:0] next_hrdata;
  logic addr_ok;
  logic [31:0] status;
  swp_state_e state;

  assign addr_ok = hsel && htrans[1] && hready;
  assign status = {11'h000, (state == SWP_RUN), sync_output_pin, burst_active,
                   direction_down, sweep_finished, 4'h0, step_index};

  always_comb begin
    next_cfg = cfg;
    next_intv = intv;
    next_blen = blen;
    next_nstep = nstep;
    next_wr_pend = addr_ok && hwrite && haddr[31:8] == 24'h000000;
    next_wr_addr = addr_ok ? haddr[7:0] : wr_addr;
    next_hrdata = hrdata;
    // Writes land in the data phase, when hwdata is valid
    if (wr_pend) begin
      if (wr_addr == SWP_CTRL_OFS) begin
        next_cfg = hwdata[7:0];
      end else if (wr_addr == SWP_INTV_OFS) begin
        next_intv = hwdata[15:0];
      end else if (wr_addr == SWP_BLEN_OFS) begin
        next_blen = hwdata[15:0];
      end else if (wr_addr == SWP_NSTEP_OFS) begin
        next_nstep = hwdata[11:0];
      end
    end
    // Read data is registered in the address phase so no wait state is needed
    if (addr_ok && !hwrite) begin
      if (haddr[7:0] == SWP_CTRL_OFS && haddr[31:8] == 24'h000000) begin
        next_hrdata = {24'h000000, cfg};
      end else if (haddr[7:0] == SWP_INTV_OFS && haddr[31:8] == 24'h000000) begin
        next_hrdata = {16'h0000, intv};
      end else if (haddr[7:0] == SWP_BLEN_OFS && haddr[31:8] == 24'h000000) begin
        next_hrdata = {16'h0000, blen};
      end else if (haddr[7:0] == SWP_NSTEP_OFS && haddr[31:8] == 24'h000000) begin
        next_hrdata = {20'h00000, nstep};
      end else if (haddr[7:0] == SWP_STAT_OFS && haddr[31:8] == 24'h000000) begin
        next_hrdata = status;
      end else begin
        next_hrdata = 32'h00000000;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg <= SWP_CTRL_RST;
      intv <= SWP_INTV_RST;
      blen <= SWP_BLEN_RST;
      nstep <= SWP_NSTEP_RST;
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
      hrdata <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else if (ce) begin
      cfg <= next_cfg;
      intv <= next_intv;
      blen <= next_blen;
      nstep <= next_nstep;
      wr_pend <= next_wr_pend;
      wr_addr <= next_wr_addr;
      hrdata <= next_hrdata;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // ****************************************
  // Mode decode and triggers
  // ****************************************
  logic running;
  logic start;
  logic ext_incr;
  logic burst_mode;
  logic ext_burst;
  logic ctrl_q;
  logic ctrl_rise;
  logic incr_evt;
  logic intv_load;
  logic blen_load;
  logic blen_tick;
  logic intv_exp;
  logic blen_exp;

  assign running = (state == SWP_RUN) && cfg[SWP_RUN_BIT];
  assign start = (state == SWP_IDLE) && cfg[SWP_RUN_BIT];
  assign ext_incr = cfg[SWP_INCR_SRC_BIT];
  assign burst_mode = !cfg[SWP_CW_BIT];
  // Burst source only counts in burst mode and with external increments
  assign ext_burst = burst_mode && ext_incr && cfg[SWP_BURST_SRC_BIT];
  assign ctrl_rise = ext_ctrl && !ctrl_q;
  assign incr_evt = running && (ext_incr ? ctrl_rise : intv_exp);
  assign intv_load = !ext_incr && (start || incr_evt);
  assign blen_load = burst_mode && !ext_burst && (start || incr_evt);
  // Burst length counts clocks or output cycles
  assign blen_tick = cfg[SWP_BUNIT_BIT] ? wave_cycle_tick : 1'b1;

  swp_timer u_intv_timer (
    .hclk(hclk),
    .hresetn(hresetn),
    .ce(ce),
    .load(intv_load),
    .load_val(intv),
    .tick(1'b1),
    .busy(),
    .expired(intv_exp)
  );

  swp_timer u_burst_timer (
    .hclk(hclk),
    .hresetn(hresetn),
    .ce(ce),
    .load(blen_load),
    .load_val(blen),
    .tick(blen_tick),
    .busy(),
    .expired(blen_exp)
  );

  // ****************************************
  // Sweep engine
  // ****************************************
  swp_state_e next_state;
  logic [11:0] next_step;
  logic next_down;
  logic next_fin;
  logic next_burst;
  logic next_sync;

  always_comb begin
    next_state = state;
    next_step = step_index;
    next_down = direction_down;
    next_fin = sweep_finished;
    next_burst = burst_active;
    if (start) begin
      next_state = SWP_RUN;
      next_step = 12'h000;
      next_down = 1'b0;
      next_fin = 1'b0;
    end else if (!running) begin
      next_state = SWP_IDLE;
    end else if (incr_evt) begin
      case (cfg[SWP_SHAPE_BIT])
        1'b1: begin
          // Sawtooth restarts from the start frequency
          if (sweep_finished) begin
            next_step = 12'h000;
            next_fin = 1'b0;
          end else begin
            next_step = step_index + 12'h001;
            next_fin = (step_index + 12'h001) == nstep;
          end
          next_down = 1'b0;
        end
        default: begin
          // Triangle runs up to the last step, then back to the start
          if (sweep_finished || !direction_down) begin
            next_step = step_index + 12'h001;
            next_down = (step_index + 12'h001) == nstep;
            next_fin = 1'b0;
          end else begin
            next_step = step_index - 12'h001;
            next_fin = step_index == 12'h001;
          end
        end
      endcase
    end
    // Burst gating: low means the output sits at midscale
    if (!running && !start) begin
      next_burst = 1'b0;
    end else if (!burst_mode) begin
      next_burst = 1'b1;
    end else if (ext_burst) begin
      next_burst = ext_ctrl;
    end else if (blen_load) begin
      next_burst = 1'b1;
    end else if (blen_exp) begin
      next_burst = 1'b0;
    end
    // Sync follows end of sweep or each increment, and only when enabled
    if (!cfg[SWP_SYNC_EN_BIT]) begin
      next_sync = 1'b0;
    end else if (cfg[SWP_SYNC_SEL_BIT]) begin
      next_sync = next_fin;
    end else begin
      next_sync = incr_evt;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= SWP_IDLE;
      step_index <= 12'h000;
      direction_down <= 1'b0;
      sweep_finished <= 1'b0;
      burst_active <= 1'b0;
      sync_output_pin <= 1'b0;
      step_pulse <= 1'b0;
      ctrl_q <= 1'b0;
    end else if (ce) begin
      state <= next_state;
      step_index <= next_step;
      direction_down <= next_down;
      sweep_finished <= next_fin;
      burst_active <= next_burst;
      sync_output_pin <= next_sync;
      step_pulse <= incr_evt;
      ctrl_q <= ext_ctrl;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  property p_burst_src_ignored;
    ce && running && ext_incr && !burst_mode |=> burst_active;
  endproperty
  a_burst_src_ignored: assert property (p_burst_src_ignored) else $error("cw mode gated");
  property p_ext_burst;
    ce && running && ext_burst |=> burst_active == $past(ext_ctrl);
  endproperty
  a_ext_burst: assert property (p_ext_burst) else $error("ext burst mismatch");
  property p_burst_end;
    ce && running && burst_mode && !ext_burst && blen_exp && !incr_evt |=> !burst_active;
  endproperty
  a_burst_end: assert property (p_burst_end) else $error("burst did not end");
  property p_burst_clocks;
    ce && running && burst_mode && !ext_burst && !cfg[SWP_BUNIT_BIT] && blen_load
      && blen == 16'h0002 ##1 ce ##1 ce |=> ce ##0 blen_exp;
  endproperty
  a_burst_clocks: assert property (p_burst_clocks) else $error("burst length off");
  property p_int_ignores_src;
    ce && running && burst_mode && !ext_incr && incr_evt |=> burst_active;
  endproperty
  a_int_ignores_src: assert property (p_int_ignores_src) else $error("burst src used");
  property p_ext_step;
    ce && running && ext_incr |=> step_pulse == $past(ctrl_rise);
  endproperty
  a_ext_step: assert property (p_ext_step) else $error("ext step wrong");
  property p_int_step;
    ce && running && !ext_incr |=> step_pulse == $past(intv_exp);
  endproperty
  a_int_step: assert property (p_int_step) else $error("int step wrong");
  property p_saw_wrap;
    ce && incr_evt && cfg[SWP_SHAPE_BIT] && sweep_finished |=> step_index == 12'h000;
  endproperty
  a_saw_wrap: assert property (p_saw_wrap) else $error("saw no restart");
  property p_tri_down;
    ce && incr_evt && !cfg[SWP_SHAPE_BIT] && direction_down && !sweep_finished
      |=> step_index == $past(step_index) - 12'h001;
  endproperty
  a_tri_down: assert property (p_tri_down) else $error("tri not down");
  property p_sync_step;
    ce && cfg[SWP_SYNC_EN_BIT] && !cfg[SWP_SYNC_SEL_BIT] |=> sync_output_pin == step_pulse;
  endproperty
  a_sync_step: assert property (p_sync_step) else $error("sync step wrong");
  property p_sync_eos;
    ce && cfg[SWP_SYNC_EN_BIT] && cfg[SWP_SYNC_SEL_BIT] |=> sync_output_pin == sweep_finished;
  endproperty
  a_sync_eos: assert property (p_sync_eos) else $error("sync eos wrong");
  property p_sync_off;
    ce && !cfg[SWP_SYNC_EN_BIT] |=> !sync_output_pin;
  endproperty
  a_sync_off: assert property (p_sync_off) else $error("sync not low");
  c_saw_wrap: cover property (ce && incr_evt && cfg[SWP_SHAPE_BIT] && sweep_finished);
  c_tri_turn: cover property (ce && incr_evt && !cfg[SWP_SHAPE_BIT] && next_down && !direction_down);
  c_ext_burst: cover property (ce && running && ext_burst && ctrl_rise);
  c_burst_mid: cover property (ce && running && burst_mode && blen_exp);
endmodule

/* File: swp_pkg.sv */
// Constants and types shared by the sweep trigger and mode decoder
package swp_pkg;
  // ****************************************
  // Register offsets (byte addresses)
  // ****************************************
  localparam logic [7:0] SWP_CTRL_OFS = 8'h00;
  localparam logic [7:0] SWP_INTV_OFS = 8'h04;
  localparam logic [7:0] SWP_BLEN_OFS = 8'h08;
  localparam logic [7:0] SWP_NSTEP_OFS = 8'h0c;
  localparam logic [7:0] SWP_STAT_OFS = 8'h10;
  // ****************************************
  // Control field positions
  // ****************************************
  localparam int SWP_RUN_BIT = 0;
  localparam int SWP_BUNIT_BIT = 1;
  localparam int SWP_SYNC_EN_BIT = 2;
  localparam int SWP_SYNC_SEL_BIT = 3;
  localparam int SWP_SHAPE_BIT = 4;
  localparam int SWP_INCR_SRC_BIT = 5;
  localparam int SWP_BURST_SRC_BIT = 6;
  localparam int SWP_CW_BIT = 7;
  // ****************************************
  // Status field positions
  // ****************************************
  localparam int SWP_ST_FIN_BIT = 16;
  localparam int SWP_ST_DOWN_BIT = 17;
  localparam int SWP_ST_BURST_BIT = 18;
  localparam int SWP_ST_SYNC_BIT = 19;
  localparam int SWP_ST_RUN_BIT = 20;
  // ****************************************
  // Widths and reset values
  // ****************************************
  localparam int SWP_CNT_W = 16;
  localparam int SWP_STEP_W = 12;
  localparam logic [7:0] SWP_CTRL_RST = 8'h80;
  localparam logic [15:0] SWP_INTV_RST = 16'h0010;
  localparam logic [15:0] SWP_BLEN_RST = 16'h0008;
  localparam logic [11:0] SWP_NSTEP_RST = 12'h00f;

  typedef enum logic [1:0] {
    SWP_IDLE = 2'b00,
    SWP_RUN = 2'b01
  } swp_state_e;
endpackage

/* File: swp_timer.sv */
// Loadable down counter that flags the end of an interval
`timescale 1ns/10ps
module swp_timer (
  // Clock, reset, enable
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  // Control
  input wire logic load,
  input wire logic [swp_pkg::SWP_CNT_W-1:0] load_val,
  input wire logic tick,
  // Status
  output logic busy,
  output logic expired
);
  import swp_pkg::*;

  logic [SWP_CNT_W-1:0] count;
  logic [SWP_CNT_W-1:0] next_count;
  logic next_busy;
  logic next_expired;

  always_comb begin
    next_count = count;
    next_busy = busy;
    next_expired = 1'b0;
    if (load) begin
      // A zero length would wrap and run the full count range, so it counts as one
      next_count = (load_val == '0) ? SWP_CNT_W'(1) : load_val;
      next_busy = 1'b1;
    end else if (busy && tick) begin
      if (count == SWP_CNT_W'(1)) begin
        next_busy = 1'b0;
        next_expired = 1'b1;
      end else begin
        next_count = count - SWP_CNT_W'(1);
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count <= '0;
      busy <= 1'b0;
      expired <= 1'b0;
    end else if (ce) begin
      count <= next_count;
      busy <= next_busy;
      expired <= next_expired;
    end
  end
endmodule

/* File: swp_trig_src.sv */
// External trigger source and waveform cycle ticker facing the sweep decoder
`timescale 1ns/10ps
module swp_trig_src #(
  parameter int WAVE_DIV = 4
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Pulse shape chosen by the bench
  input wire logic en,
  input wire logic [3:0] hi_len,
  input wire logic [3:0] lo_len,
  // Pins toward the block
  output logic ext_ctrl,
  output logic wave_cycle_tick
);
  logic [4:0] cnt, next_cnt;
  logic [3:0] wdiv, next_wdiv;
  logic next_ext;
  // Low phase first, so every rising edge follows at least one low cycle
  always_comb begin
    next_cnt = (!en || cnt >= 5'(hi_len) + 5'(lo_len) - 5'h01) ? 5'h00 : cnt + 5'h01;
    next_ext = en && (cnt >= 5'(lo_len));
    next_wdiv = (wdiv == 4'(WAVE_DIV - 1)) ? 4'h0 : wdiv + 4'h1;
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt <= 5'h00;
      ext_ctrl <= 1'b0;
      wdiv <= 4'h0;
      wave_cycle_tick <= 1'b0;
    end else begin
      cnt <= next_cnt;
      ext_ctrl <= next_ext;
      wdiv <= next_wdiv;
      wave_cycle_tick <= (wdiv == 4'h0);
    end
  end
endmodule

/* File: tb_swp_decode.sv */
// Self-checking bench for the sweep trigger and mode decoder
`timescale 1ns/10ps
module tb_swp_decode;
  import swp_pkg::*;
  // ****************************************
  // Signals and instances
  // ****************************************
  localparam int NS = 3;
  localparam int BL = 2;
  localparam int IV = 9;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, rd;
  logic hreadyout, hresp, ext_ctrl, wave_cycle_tick, direction_down, step_pulse;
  logic burst_active, sweep_finished, sync_output_pin, down, fin;
  logic [11:0] step_index;
  logic src_en = 1'b0;
  logic ce = 1'b1;
  logic [3:0] lo_len = 4'h5;
  logic [31:0] ra [5] = '{32'h04, 32'h08, 32'h0c, 32'h10, 32'h14};
  logic [31:0] rw [5] = '{32'habcd0009, 32'hffff0002, 32'hfffff003, 32'hffffffff, 32'hffffffff};
  logic [31:0] rx [5] = '{32'h9, 32'h2, 32'h3, 32'h0, 32'h0};
  int mismatches = 0;
  int comparisons = 0;
  int steps, hl, idx;
  always #20 hclk = ~hclk;
  swp_decode u_swp_decode (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .ext_ctrl(ext_ctrl), .wave_cycle_tick(wave_cycle_tick), .step_index(step_index),
    .direction_down(direction_down), .step_pulse(step_pulse), .burst_active(burst_active),
    .sweep_finished(sweep_finished), .sync_output_pin(sync_output_pin));
  swp_trig_src u_swp_trig_src (.hclk(hclk), .hresetn(hresetn), .en(src_en), .hi_len(4'h2),
    .lo_len(lo_len), .ext_ctrl(ext_ctrl), .wave_cycle_tick(wave_cycle_tick));
  // ****************************************
  // Tasks
  // ****************************************
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_sim();
    if (mismatches == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Slave has no wait states, but the master never assumes that
  task automatic wait_rdy();
    for (int i = 0; i < 50; i++) begin
      @(posedge hclk);
      if (hreadyout === 1'b1) return;
    end
    mismatches++;
    end_sim();
  endtask
  task automatic ahb(input logic [31:0] a, input logic w, input logic [31:0] wd);
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    hsel <= 1'b1;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata;
    check(hresp, 1'b0);
  endtask
  task automatic watch(input int n, input logic [7:0] c);
    logic e1, e2;
    logic intb;
    int lk;
    e1 = 1'b0;
    lk = 0;
    e2 = 1'b0;
    intb = !c[7] && !(c[5] && c[6]);
    for (int k = 0; k < n; k++) begin
      @(posedge hclk);
      #1;
      if (!c[2]) check(sync_output_pin, 1'b0);
      else if (c[3]) check(sync_output_pin, sweep_finished);
      else check(sync_output_pin, step_pulse);
      if (c[5] && k >= 2) check(step_pulse, e1 & ~e2);
      if (c[7] && k >= 3) check(burst_active, 1'b1);
      if (!c[7] && c[5] && c[6] && k >= 2) check(burst_active, e1);
      if (intb && burst_active === 1'b1) hl++;
      else if (intb && hl > 0) begin
        if (c[1]) check(hl > BL + 2, 1'b1);
        else check(hl >= BL && hl <= BL + 2, 1'b1);
        hl = 0;
      end
      if (step_pulse === 1'b1) begin
        steps++;
        // Internal steps come one interval plus one clock apart, counted from start
        if (!c[5]) check(k - lk, IV + 1);
        lk = k;
        if (c[4]) idx = (idx == NS) ? 0 : idx + 1;
        else begin
          if (idx == 0) down = 1'b0;
          idx = down ? idx - 1 : idx + 1;
          if (idx == NS) down = 1'b1;
        end
        fin = c[4] ? (idx == NS) : (down && idx == 0);
        check(step_index, idx);
        check(sweep_finished, fin);
        if (!c[4] && idx != 0) check(direction_down, down);
        if (intb) check(burst_active, 1'b1);
      end
      e2 = e1;
      e1 = ext_ctrl;
    end
  endtask
  task automatic run(input logic [7:0] c, input logic en, input logic [3:0] lo, input int n);
    ahb(32'h0, 1'b1, 32'h80);
    ahb(32'h0, 1'b1, {24'h0, c});
    idx = 0;
    down = 1'b0;
    fin = 1'b0;
    hl = 0;
    steps = 0;
    src_en <= en;
    lo_len <= lo;
    watch(n, c);
    src_en <= 1'b0;
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (16) @(posedge hclk);
    check(hreadyout, 1'b1);
    check(sync_output_pin, 1'b0);
    hresetn <= 1'b1;
    @(posedge hclk);
    ahb({24'h0, SWP_CTRL_OFS}, 1'b0, 32'h0);
    check(rd, 32'h80);
    ahb({24'h0, SWP_INTV_OFS}, 1'b0, 32'h0);
    check(rd, 32'h10);
    ahb({24'h0, SWP_BLEN_OFS}, 1'b0, 32'h0);
    check(rd, 32'h8);
    ahb({24'h0, SWP_NSTEP_OFS}, 1'b0, 32'h0);
    check(rd, 32'hf);
    for (int r = 0; r < 5; r++) begin
      ahb(ra[r], 1'b1, rw[r]);
      ahb(ra[r], 1'b0, 32'h0);
      check(rd, rx[r]);
    end
    run(8'h95, 1'b0, 4'h5, 80);
    check(steps > 0, 1'b1);
    // Clock enable low must freeze a running sweep
    ce <= 1'b0;
    @(posedge hclk);
    rd = {20'h0, step_index};
    repeat (30) @(posedge hclk);
    check({20'h0, step_index}, rd);
    ce <= 1'b1;
    run(8'h8d, 1'b0, 4'h5, 80);
    run(8'h99, 1'b0, 4'h5, 60);
    run(8'hb5, 1'b0, 4'h5, 30);
    check(steps, 0);
    run(8'hb5, 1'b1, 4'h5, 60);
    check(steps > 0, 1'b1);
    run(8'h21, 1'b1, 4'hf, 80);
    run(8'h23, 1'b1, 4'hf, 80);
    run(8'h61, 1'b1, 4'h6, 60);
    // External pulses run here to show they steer neither steps nor bursts
    run(8'h41, 1'b1, 4'h5, 80);
    check(steps > 0, 1'b1);
    run(8'he1, 1'b1, 4'h5, 60);
    hresetn <= 1'b0;
    @(posedge hclk);
    #1;
    check(step_pulse, 1'b0);
    check(burst_active, 1'b0);
    check(sync_output_pin, 1'b0);
    @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    ahb({24'h0, SWP_CTRL_OFS}, 1'b0, 32'h0);
    check(rd, 32'h80);
    end_sim();
  end
endmodule
